// >>> bench/qnfe_link_assertions.sv
`timescale 1ns/1ps
module qnfe_link_assertions (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Link signals
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] h_io_oe_n,
	input wire logic [3:0] d_io_o,
	input wire logic [3:0] d_io_oe_n,
	input wire logic [3:0] io
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);

	a_reset_idle: assert property ($fell(reset_in) |-> cs_n && d_io_oe_n == 4'hf)
		else $error("link not idle after reset");
	a_desel_float: assert property (cs_n [*8] |-> d_io_oe_n == 4'hf)
		else $error("device drives while deselected");
	a_out_on_fall: assert property (!cs_n && $changed(d_io_o & ~d_io_oe_n) |-> !sclk)
		else $error("device output changed while clock high");
	a_lane_use: assert property (d_io_oe_n inside {4'hf, 4'hd, 4'hc, 4'h0})
		else $error("device drives an illegal lane set");
	a_pause_float: assert property (
		(!cs_n && !h_io_oe_n[3] && !io[3] && !sclk) [*8] |-> ##2 d_io_oe_n == 4'hf)
		else $error("device drives while paused");
	a_cs_clock_low: assert property ($changed(cs_n) |-> !sclk)
		else $error("select moved with clock high");
	a_idle_clock: assert property (cs_n |-> !sclk)
		else $error("clock runs while deselected");
	a_half_period: assert property ($changed(sclk) |=> $stable(sclk) [*7])
		else $error("clock half period too short");
	a_pause_idle_high: assert property (cs_n [*2] |-> io[3])
		else $error("pause pin low while idle");

	c_quad: cover property (d_io_oe_n == 4'h0);
	c_dual: cover property (d_io_oe_n == 4'hc);
	c_single: cover property (d_io_oe_n == 4'hd);
	c_pause: cover property ((!cs_n && !h_io_oe_n[3] && !io[3] && !sclk) [*8]);
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	// Clock, reset and register port
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	// Array side
	logic busy = 1'b0;
	logic [1:0] ecc = 2'h0;
	logic rx_valid;
	logic [7:0] rx_byte;
	logic [qnfe_pkg::COL_W-1:0] col;
	logic op_valid;
	logic [1:0] op_kind;
	logic [qnfe_pkg::PAGE_W-1:0] op_page;
	logic [1:0] area;
	logic [7:0] tx_byte;
	// Bench state
	logic wp = 1'b1;
	logic [17:0] last_op;
	logic [18:0] last_rx;
	logic [7:0] b;
	logic [7:0] b2;
	logic [7:0] rop [3] = '{qnfe_pkg::OP_READ1, qnfe_pkg::OP_READ2, qnfe_pkg::OP_READ4};
	logic [1:0] rln [3] = '{qnfe_pkg::LN_1, qnfe_pkg::LN_2, qnfe_pkg::LN_4};
	int n_ops = 0;
	int i;
	int failures = 0;
	int comparisons = 0;

	qnfe_link_if i_qnfe_link_if ();
	assign tx_byte = col[7:0] ^ 8'h5a;
	qnfe_host i_qnfe_host (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdata), .link(i_qnfe_link_if.host_mp));
	qnfe_dev #(.PAGE_BYTES(qnfe_pkg::PAGE_BYTES)) i_qnfe_dev (.clk_in(clk_in), .reset_in(reset_in),
		.link(i_qnfe_link_if.dev_mp), .busy_in(busy), .ecc_in(ecc), .tx_byte_in(tx_byte),
		.rx_valid_out(rx_valid), .rx_byte_out(rx_byte), .col_out(col), .op_valid_out(op_valid),
		.op_kind_out(op_kind), .op_page_out(op_page), .area_out(area));
	qnfe_link_assertions i_qnfe_link_assertions (.clk_in(clk_in), .reset_in(reset_in),
		.cs_n(i_qnfe_link_if.cs_n), .sclk(i_qnfe_link_if.sclk), .h_io_oe_n(i_qnfe_link_if.h_io_oe_n),
		.d_io_o(i_qnfe_link_if.d_io_o), .d_io_oe_n(i_qnfe_link_if.d_io_oe_n), .io(i_qnfe_link_if.io));

	initial
		forever #2.5 clk_in = ~clk_in;

	// Records array operations and loaded bytes.
	always @(posedge clk_in)
	begin
		if (op_valid === 1'b1)
		begin
			n_ops <= n_ops + 1;
			last_op <= {op_kind, op_page};
		end
		if (rx_valid === 1'b1)
			last_rx <= {col, rx_byte};
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR at %0t: seen %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d, failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Called right after a rising edge; returns on a rising edge.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
		@(posedge clk_in);
	endtask

	// The read data are taken at the edge that ends the cycle after the strobe.
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		@(posedge clk_in);
		d = rdata;
	endtask

	function automatic logic [7:0] cv(input logic [7:0] x);
		return x | {5'h0, wp, 2'h0};
	endfunction

	// Shifts one byte and waits until the host is idle again.
	task automatic sb(input logic [7:0] v);
		logic [7:0] s;
		int k;
		wr_reg(qnfe_pkg::H_DATA, v);
		for (k = 0; k < 400; k++)
		begin
			rd_reg(qnfe_pkg::H_STAT, s);
			if (s[0] === 1'b0)
				break;
		end
		if (k == 400)
		begin
			failures++;
			complete_run();
		end
	endtask

	task automatic desel();
		wr_reg(qnfe_pkg::H_CTRL, cv(8'h00));
		repeat (8) @(posedge clk_in);
	endtask

	// Sends n bytes of v, most significant first, in one frame.
	task automatic cmd(input int n, input logic [31:0] v);
		int j;
		wr_reg(qnfe_pkg::H_CTRL, cv(8'h01));
		for (j = 0; j < n; j++)
			sb(v[31-8*j -: 8]);
		desel();
	endtask

	task automatic wop(input logic [31:0] v);
		cmd(1, {qnfe_pkg::OP_WREN, 24'h0});
		cmd(3, v);
	endtask

	// Reads a device register, optionally pausing after the device starts driving the first data bit.
	task automatic getr(input logic [7:0] sel, input bit pz, output logic [7:0] d);
		wr_reg(qnfe_pkg::H_CTRL, cv(8'h01));
		sb(qnfe_pkg::OP_GETR);
		sb(sel);
		if (pz)
		begin
			repeat (6) @(posedge clk_in);
			chk(i_qnfe_link_if.d_io_oe_n, 4'hd);
			wr_reg(qnfe_pkg::H_CTRL, cv(8'h03));
			repeat (12) @(posedge clk_in);
			chk(i_qnfe_link_if.d_io_oe_n, 4'hf);
		end
		wr_reg(qnfe_pkg::H_CTRL, cv(8'h41));
		sb(8'h00);
		rd_reg(qnfe_pkg::H_DATA, d);
		desel();
	endtask

	task automatic rda(input logic [7:0] op, input logic [1:0] ln, output logic [7:0] d0,
		output logic [7:0] d1);
		cmd(0, 32'h0);
		wr_reg(qnfe_pkg::H_CTRL, cv(8'h01));
		sb(op);
		sb(8'h00);
		sb(8'h00);
		sb(8'h00);
		wr_reg(qnfe_pkg::H_CTRL, cv(8'h41) | {2'h0, ln, 4'h0});
		sb(8'h00);
		rd_reg(qnfe_pkg::H_DATA, d0);
		sb(8'h00);
		rd_reg(qnfe_pkg::H_DATA, d1);
		desel();
	endtask

	initial
	begin
		repeat (100000) @(posedge clk_in);
		failures++;
		complete_run();
	end

	initial
	begin
		repeat (8) @(posedge clk_in);
		reset_in <= 1'b0;
		rd_reg(qnfe_pkg::H_DIV, b);
		chk(b, qnfe_pkg::DIV_RST);
		chk({i_qnfe_link_if.cs_n, i_qnfe_link_if.d_io_oe_n}, 5'h1f);
		rd_reg(8'h10, b);
		chk(b, 8'h00);
		chk(area, qnfe_pkg::AREA_MAIN);
		wr_reg(qnfe_pkg::H_DIV, qnfe_pkg::DIV_MIN);
		$display("test reset done");
		@(posedge clk_in);
		busy <= 1'b1;
		ecc <= 2'h2;
		getr(qnfe_pkg::RA_STAT, 1'b1, b);
		chk(b, 8'h21);
		@(posedge clk_in);
		busy <= 1'b0;
		$display("test status and pause done");
		cmd(1, {qnfe_pkg::OP_WREN, 24'h0});
		getr(qnfe_pkg::RA_STAT, 1'b0, b);
		chk(b, 8'h22);
		cmd(3, {qnfe_pkg::OP_PROG, 16'h0005, 8'h0});
		chk({n_ops[7:0], last_op}, {8'h1, qnfe_pkg::OPK_PROG, 16'h0005});
		getr(qnfe_pkg::RA_STAT, 1'b0, b);
		chk(b, 8'h20);
		cmd(3, {qnfe_pkg::OP_PREAD, 16'hffff, 8'h0});
		chk({n_ops[7:0], last_op}, {8'h2, qnfe_pkg::OPK_READ, 16'hffff});
		cmd(1, {qnfe_pkg::OP_WREN, 24'h0});
		cmd(2, {qnfe_pkg::OP_PROG, 8'h00, 16'h0});
		getr(qnfe_pkg::RA_STAT, 1'b0, b);
		chk({n_ops[7:0], b}, {8'h2, 8'h22});
		$display("test program done");
		cmd(3, {qnfe_pkg::OP_SETR, qnfe_pkg::RA_PROT, 8'h08, 8'h0});
		cmd(3, {qnfe_pkg::OP_PROG, 16'hff80, 8'h0});
		getr(qnfe_pkg::RA_STAT, 1'b0, b);
		chk({n_ops[7:0], b & 8'h04}, {8'h2, 8'h04});
		wop({qnfe_pkg::OP_PROG, 16'hff7f, 8'h0});
		chk({n_ops[7:0], last_op}, {8'h3, qnfe_pkg::OPK_PROG, 16'hff7f});
		cmd(3, {qnfe_pkg::OP_SETR, qnfe_pkg::RA_PROT, 16'h0});
		wop({qnfe_pkg::OP_ERASE, 16'h00c0, 8'h0});
		chk({n_ops[7:0], last_op}, {8'h4, qnfe_pkg::OPK_ERASE, 16'h00c0});
		$display("test protect and erase done");
		cmd(3, {qnfe_pkg::OP_SETR, qnfe_pkg::RA_CONF, 8'h01, 8'h0});
		chk(area, qnfe_pkg::AREA_OTP);
		wop({qnfe_pkg::OP_PROG, qnfe_pkg::OTP_PAGES, 8'h0});
		chk(n_ops, 4);
		wop({qnfe_pkg::OP_PROG, qnfe_pkg::OTP_PAGES - 16'h1, 8'h0});
		chk({n_ops[7:0], last_op}, {8'h5, qnfe_pkg::OPK_PROG, 16'h0009});
		wop({qnfe_pkg::OP_ERASE, 24'h0});
		chk(n_ops, 5);
		cmd(3, {qnfe_pkg::OP_SETR, qnfe_pkg::RA_CONF, 16'h0});
		$display("test one-time pages done");
		cmd(3, {qnfe_pkg::OP_SETR, qnfe_pkg::RA_PROT, 8'h01, 8'h0});
		wp = 1'b0;
		cmd(3, {qnfe_pkg::OP_SETR, qnfe_pkg::RA_PROT, 16'h0});
		getr(qnfe_pkg::RA_PROT, 1'b0, b);
		chk(b, 8'h01);
		wp = 1'b1;
		cmd(3, {qnfe_pkg::OP_SETR, qnfe_pkg::RA_PROT, 8'h02, 8'h0});
		wp = 1'b0;
		wop({qnfe_pkg::OP_PROG, 16'h0005, 8'h0});
		getr(qnfe_pkg::RA_STAT, 1'b0, b);
		chk({n_ops[7:0], b & 8'h04}, {8'h5, 8'h04});
		wp = 1'b1;
		rda(qnfe_pkg::OP_READ4, qnfe_pkg::LN_4, b, b2);
		chk({b, b2}, 16'hffff);
		cmd(3, {qnfe_pkg::OP_SETR, qnfe_pkg::RA_PROT, 16'h0});
		getr(qnfe_pkg::RA_PROT, 1'b0, b);
		chk(b, qnfe_pkg::PROT_RST);
		$display("test write protect done");
		for (i = 0; i < 3; i++)
		begin
			rda(rop[i], rln[i], b, b2);
			chk({b, b2}, 16'h5a5b);
		end
		cmd(4, {qnfe_pkg::OP_LOADS, 16'h0003, 8'ha5});
		chk(last_rx, {11'h003, 8'ha5});
		$display("test lanes and load done");
		complete_run();
	end
endmodule

// >>> hdl/qnfe_dev.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [RQ1] Deselected device floats every data lane.
// [RQ2] First select edge needed before instructions.
// [RQ3] Single lane: in on rise, out on fall.
// [RQ4] Dual and quad lanes: same edge usage.
// [RQ5] Lanes 0-1 normally; quad adds lanes 2-3.
// [RQ6] Protect enable off: pin guards protection_reg.
// [RQ7] Protect enable on: low pin blocks writes.
// [RQ8] Protect enable on: quad reads refused.
// [RQ9] Pause floats output, ignores clock and input.
// [RQ10] Pause release resumes without losing state.
// [RQ11] Quad operation: pause pin is lane 3.
// [RQ12] Host keeps pause pin driven high.
// [RQ13] Array is 65536 pages of 2048 bytes.
// [RQ14] Erase whole 64-page blocks, 1024 blocks.
// [RQ15] Program writes a whole page buffer.
// [RQ16] Unique, parameter and ten one-time pages.
// [RQ17] One-time pages never erase.
// [RQ18] Correction outcome reported in status bits.
// [RQ19] Protected region from 256KB up to all.
// [RQ20] Clock idle low or high both accepted.
// [RQ21] Pause starts and ends while clock low.
// [RQ22] Select rise discards a partial instruction.
module qnfe_dev #(
	parameter int PAGE_BYTES = qnfe_pkg::PAGE_BYTES
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Link to the host
	qnfe_link_if.dev_mp link,
	// Array side
	input wire logic busy_in,
	input wire logic [1:0] ecc_in,
	input wire logic [7:0] tx_byte_in,
	output logic rx_valid_out,
	output logic [7:0] rx_byte_out,
	output logic [qnfe_pkg::COL_W-1:0] col_out,
	output logic op_valid_out,
	output logic [1:0] op_kind_out,
	output logic [qnfe_pkg::PAGE_W-1:0] op_page_out,
	output logic [1:0] area_out
);
	if (PAGE_BYTES != (1 << qnfe_pkg::COL_W))
	begin : g_bad_page
		$error("Page size must match the column width.");
	end

	typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_WDATA, PH_RDATA, PH_DONE} qnfe_phase_t;
	typedef struct packed {
		logic [2:0] cs_s;
		logic [2:0] ck_s;
		logic [3:0] io_s1;
		logic [3:0] io_s2;
		logic armed;
		logic hold;
		logic qlock;
		logic drv;
		qnfe_phase_t ph;
		logic [7:0] cmd;
		logic [7:0] sr;
		logic [7:0] tx;
		logic [3:0] bits;
		logic [1:0] nadr;
		logic [15:0] adr;
		logic [1:0] lanes;
		logic [7:0] prot;
		logic [7:0] conf;
		logic wel;
		logic refused;
		logic [3:0] dout;
		logic [3:0] oe_n;
		logic rxv;
		logic [7:0] rxb;
		logic [qnfe_pkg::COL_W-1:0] col;
		logic opv;
		logic [1:0] opk;
		logic [15:0] page;
	} qnfe_dev_st_t;

	qnfe_dev_st_t r_r;
	qnfe_dev_st_t r_nxt;
	logic cs_lo, ck_rise, ck_fall, act, wpe, wr_block, prot_hit, otp_bad;
	logic deny_pg, deny_er, prot_ok, is_rd;
	logic [3:0] wv, left, bpf;
	logic [7:0] rx_b, stat, reg_q, tx_b;
	logic [15:0] fa;
	logic [8:0] lim;
	logic [1:0] area, rpf;

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		r_nxt = r_r;
		r_nxt.rxv = 1'b0;
		r_nxt.opv = 1'b0;
		r_nxt.cs_s = {r_r.cs_s[1:0], link.cs_n};
		r_nxt.ck_s = {r_r.ck_s[1:0], link.sclk};
		r_nxt.io_s1 = link.io;
		r_nxt.io_s2 = r_r.io_s1;
		cs_lo = ~r_r.cs_s[1];
		ck_rise = r_r.ck_s[1] & ~r_r.ck_s[2];
		ck_fall = ~r_r.ck_s[1] & r_r.ck_s[2];
		act = cs_lo & r_r.armed & ~r_r.hold;
		wpe = r_r.prot[qnfe_pkg::PROT_WPE];
		wr_block = wpe & ~r_r.io_s2[2];
		rpf = {r_r.prot[qnfe_pkg::PROT_RP1], r_r.prot[qnfe_pkg::PROT_RP0]};
		prot_ok = ~wr_block & ~(~wpe & ~r_r.io_s2[2] & (rpf != 2'h0)); // RQ6 RQ7
		bpf = r_r.prot[qnfe_pkg::PROT_BPF_LO +: 4];
		area = r_r.conf[1:0];
		is_rd = (r_r.cmd == qnfe_pkg::OP_READ1) || (r_r.cmd == qnfe_pkg::OP_READ2)
			|| (r_r.cmd == qnfe_pkg::OP_READ4);
		case (r_r.lanes)
			qnfe_pkg::LN_4: wv = 4'h4;
			qnfe_pkg::LN_2: wv = 4'h2;
			default: wv = 4'h1;
		endcase
		case (r_r.lanes) // RQ3 RQ4 RQ5
			qnfe_pkg::LN_4: rx_b = {r_r.sr[3:0], r_r.io_s2};
			qnfe_pkg::LN_2: rx_b = {r_r.sr[5:0], r_r.io_s2[1:0]};
			default: rx_b = {r_r.sr[6:0], r_r.io_s2[0]};
		endcase
		fa = {r_r.adr[7:0], rx_b};
		lim = 9'(qnfe_pkg::PROT_UNITS - (10'h001 << (bpf - 4'h1)));
		prot_hit = (bpf != 4'h0) && ((bpf >= qnfe_pkg::BPF_ALL)
			|| (fa[qnfe_pkg::PAGE_W-1:qnfe_pkg::UNIT_LSB] >= lim)); // RQ19
		otp_bad = (area == qnfe_pkg::AREA_OTP) && (fa >= qnfe_pkg::OTP_PAGES); // RQ16
		deny_pg = ~r_r.wel | wr_block | ((area == qnfe_pkg::AREA_MAIN) & prot_hit)
			| (area == qnfe_pkg::AREA_UNIQ) | (area == qnfe_pkg::AREA_PARAM) | otp_bad; // RQ7
		deny_er = ~r_r.wel | wr_block | (area != qnfe_pkg::AREA_MAIN) | prot_hit; // RQ17
		stat = 8'h00;
		stat[qnfe_pkg::ST_BUSY] = busy_in;
		stat[qnfe_pkg::ST_WEL] = r_r.wel;
		stat[qnfe_pkg::ST_REF] = r_r.refused;
		stat[qnfe_pkg::ST_ECC_LO +: 2] = ecc_in; // RQ18
		case (r_r.adr[7:0])
			qnfe_pkg::RA_PROT: reg_q = r_r.prot;
			qnfe_pkg::RA_CONF: reg_q = r_r.conf;
			qnfe_pkg::RA_STAT: reg_q = stat;
			default: reg_q = 8'h00;
		endcase
		left = (r_r.bits == 4'h0) ? 4'h8 : r_r.bits;
		tx_b = r_r.tx;
		if (r_r.bits == 4'h0)
			tx_b = (r_r.cmd == qnfe_pkg::OP_GETR) ? reg_q : tx_byte_in;

		if (cs_lo && r_r.cs_s[2])
			r_nxt.armed = 1'b1; // RQ2
		if (!cs_lo || r_r.qlock)
			r_nxt.hold = 1'b0; // RQ11
		else if (!r_r.ck_s[1])
			r_nxt.hold = ~r_r.io_s2[3]; // RQ9 RQ10 RQ21

		// Input side: lanes are taken on the rising clock edge.
		if (ck_rise && act && r_r.ph != PH_RDATA && r_r.ph != PH_DONE)
		begin
			r_nxt.sr = rx_b;
			r_nxt.bits = r_r.bits + wv;
			if (r_r.bits + wv == 4'h8)
			begin
				r_nxt.bits = 4'h0;
				case (r_r.ph)
					PH_IDLE:
					begin
						r_nxt.cmd = rx_b;
						r_nxt.ph = PH_ADDR;
						r_nxt.nadr = 2'h2;
						case (rx_b)
							qnfe_pkg::OP_WREN:
							begin
								r_nxt.wel = 1'b1;
								r_nxt.ph = PH_DONE;
							end
							qnfe_pkg::OP_WRDI:
							begin
								r_nxt.wel = 1'b0;
								r_nxt.ph = PH_DONE;
							end
							qnfe_pkg::OP_GETR, qnfe_pkg::OP_SETR:
								r_nxt.nadr = 2'h1;
							qnfe_pkg::OP_READ4, qnfe_pkg::OP_LOADQ:
							begin
								r_nxt.qlock = ~wpe; // RQ11
								r_nxt.nadr = (rx_b == qnfe_pkg::OP_READ4) ? 2'h3 : 2'h2;
								if (wpe)
								begin
									r_nxt.ph = PH_DONE; // RQ8
									r_nxt.refused = 1'b1;
								end
							end
							qnfe_pkg::OP_READ1, qnfe_pkg::OP_READ2:
								r_nxt.nadr = 2'h3;
							qnfe_pkg::OP_LOADS, qnfe_pkg::OP_PROG, qnfe_pkg::OP_ERASE,
								qnfe_pkg::OP_PREAD:
								r_nxt.nadr = 2'h2;
							default:
								r_nxt.ph = PH_DONE;
						endcase
					end
					PH_ADDR:
					begin
						r_nxt.nadr = r_r.nadr - 2'h1;
						if (!(is_rd && r_r.nadr == 2'h1))
							r_nxt.adr = fa;
						if (r_r.nadr == 2'h1)
						begin
							r_nxt.ph = PH_DONE;
							case (r_r.cmd)
								qnfe_pkg::OP_GETR:
									r_nxt.ph = PH_RDATA;
								qnfe_pkg::OP_SETR:
									r_nxt.ph = PH_WDATA;
								qnfe_pkg::OP_LOADS, qnfe_pkg::OP_LOADQ:
								begin
									r_nxt.ph = PH_WDATA;
									r_nxt.col = fa[qnfe_pkg::COL_W-1:0] - 11'h001;
									if (r_r.cmd == qnfe_pkg::OP_LOADQ)
										r_nxt.lanes = qnfe_pkg::LN_4; // RQ5
								end
								qnfe_pkg::OP_READ1, qnfe_pkg::OP_READ2, qnfe_pkg::OP_READ4:
								begin
									r_nxt.ph = PH_RDATA;
									r_nxt.col = r_r.adr[qnfe_pkg::COL_W-1:0]; // RQ13
									if (r_r.cmd == qnfe_pkg::OP_READ2)
										r_nxt.lanes = qnfe_pkg::LN_2;
									if (r_r.cmd == qnfe_pkg::OP_READ4)
										r_nxt.lanes = qnfe_pkg::LN_4;
								end
								qnfe_pkg::OP_PROG:
								begin
									r_nxt.refused = deny_pg; // RQ15
									r_nxt.opv = ~deny_pg;
									r_nxt.opk = qnfe_pkg::OPK_PROG;
									r_nxt.page = fa;
									r_nxt.wel = 1'b0;
								end
								qnfe_pkg::OP_ERASE:
								begin
									r_nxt.refused = deny_er;
									r_nxt.opv = ~deny_er;
									r_nxt.opk = qnfe_pkg::OPK_ERASE;
									r_nxt.page = {fa[qnfe_pkg::PAGE_W-1:qnfe_pkg::BLOCK_LSB], 6'h00}; // RQ14
									r_nxt.wel = 1'b0;
								end
								qnfe_pkg::OP_PREAD:
								begin
									r_nxt.refused = otp_bad;
									r_nxt.opv = ~otp_bad;
									r_nxt.opk = qnfe_pkg::OPK_READ;
									r_nxt.page = fa; // RQ13
								end
								default:
									r_nxt.ph = PH_DONE;
							endcase
						end
					end
					PH_WDATA:
					begin
						if (r_r.cmd == qnfe_pkg::OP_SETR)
						begin
							r_nxt.ph = PH_DONE;
							r_nxt.refused = 1'b1;
							if (r_r.adr[7:0] == qnfe_pkg::RA_PROT && prot_ok)
							begin
								r_nxt.prot = rx_b; // RQ6
								r_nxt.refused = 1'b0;
							end
							if (r_r.adr[7:0] == qnfe_pkg::RA_CONF && !wr_block)
							begin
								r_nxt.conf = rx_b; // RQ7
								r_nxt.refused = 1'b0;
							end
						end
						else
						begin
							r_nxt.rxv = 1'b1; // RQ15
							r_nxt.rxb = rx_b;
							r_nxt.col = r_r.col + 11'h001;
						end
					end
					default:
						r_nxt.ph = r_r.ph;
				endcase
			end
		end

		// Output side: a new lane group on every falling clock edge of the read data phase.
		if (ck_fall && act && r_r.ph == PH_RDATA) // RQ20
		begin
			r_nxt.drv = 1'b1;
			case (r_r.lanes) // RQ3 RQ4 RQ5
				qnfe_pkg::LN_4: r_nxt.dout = tx_b[7:4];
				qnfe_pkg::LN_2: r_nxt.dout[1:0] = tx_b[7:6];
				default: r_nxt.dout[1] = tx_b[7];
			endcase
			r_nxt.tx = tx_b << wv;
			r_nxt.bits = left - wv;
			if (r_r.bits == 4'h0 && r_r.cmd != qnfe_pkg::OP_GETR)
				r_nxt.col = r_r.col + 11'h001;
		end

		r_nxt.oe_n = 4'hf;
		if (cs_lo && !r_r.hold && r_r.drv) // RQ1 RQ9
		begin
			case (r_r.lanes)
				qnfe_pkg::LN_4: r_nxt.oe_n = 4'h0;
				qnfe_pkg::LN_2: r_nxt.oe_n = 4'hc;
				default: r_nxt.oe_n = 4'hd;
			endcase
		end

		if (!cs_lo) // RQ22
		begin
			r_nxt.ph = PH_IDLE;
			r_nxt.bits = 4'h0;
			r_nxt.nadr = 2'h0;
			r_nxt.qlock = 1'b0;
			r_nxt.drv = 1'b0;
			r_nxt.lanes = qnfe_pkg::LN_1;
		end

		if (reset_in)
		begin
			r_nxt = '0;
			r_nxt.oe_n = 4'hf;
			r_nxt.prot = qnfe_pkg::PROT_RST;
			r_nxt.conf = qnfe_pkg::CONF_RST;
		end
	end

	always_ff @(posedge clk_in)
	begin
		r_r <= r_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	assign link.d_io_o = r_r.dout;
	assign link.d_io_oe_n = r_r.oe_n;
	assign rx_valid_out = r_r.rxv;
	assign rx_byte_out = r_r.rxb;
	assign col_out = r_r.col;
	assign op_valid_out = r_r.opv;
	assign op_kind_out = r_r.opk;
	assign op_page_out = r_r.page;
	assign area_out = r_r.conf[1:0];
endmodule

// >>> hdl/qnfe_host.sv
`timescale 1ns/1ps
module qnfe_host (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Register port
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// Link to the device
	qnfe_link_if.host_mp link
);
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic [3:0] io_o;
		logic [3:0] oe_n;
		logic hold;
		logic wp;
		logic [1:0] lanes;
		logic rd;
		logic [7:0] div;
		logic [7:0] cnt;
		logic [7:0] sr;
		logic [7:0] rx;
		logic [3:0] bits;
		logic busy;
		logic [7:0] rdata;
	} qnfe_host_st_t;

	qnfe_host_st_t r_r;
	qnfe_host_st_t r_nxt;
	logic [7:0] hp, src, ctrlv;
	logic [3:0] wv;
	logic shift_now;

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		r_nxt = r_r;
		r_nxt.rdata = 8'h00;
		hp = (r_r.div < qnfe_pkg::DIV_MIN) ? qnfe_pkg::DIV_MIN : r_r.div;
		case (r_r.lanes)
			qnfe_pkg::LN_4: wv = 4'h4;
			qnfe_pkg::LN_2: wv = 4'h2;
			default: wv = 4'h1;
		endcase
		ctrlv = 8'h00;
		ctrlv[qnfe_pkg::CTRL_SEL] = ~r_r.cs_n;
		ctrlv[qnfe_pkg::CTRL_HOLD] = r_r.hold;
		ctrlv[qnfe_pkg::CTRL_WP] = r_r.wp;
		ctrlv[qnfe_pkg::CTRL_LN_LO +: 2] = r_r.lanes;
		ctrlv[qnfe_pkg::CTRL_RD] = r_r.rd;
		src = r_r.sr;
		shift_now = 1'b0;

		if (wr_in && addr_in == qnfe_pkg::H_CTRL)
		begin
			r_nxt.cs_n = ~wdata_in[qnfe_pkg::CTRL_SEL]; // RQ2
			r_nxt.hold = wdata_in[qnfe_pkg::CTRL_HOLD];
			r_nxt.wp = wdata_in[qnfe_pkg::CTRL_WP];
			r_nxt.lanes = wdata_in[qnfe_pkg::CTRL_LN_LO +: 2];
			r_nxt.rd = wdata_in[qnfe_pkg::CTRL_RD];
		end
		if (wr_in && addr_in == qnfe_pkg::H_DIV)
			r_nxt.div = wdata_in;
		if (wr_in && addr_in == qnfe_pkg::H_DATA && !r_r.busy)
		begin
			r_nxt.busy = 1'b1;
			r_nxt.bits = 4'h8;
			r_nxt.cnt = 8'h00;
			r_nxt.sclk = 1'b0; // RQ20
			src = wdata_in;
			shift_now = 1'b1;
		end
		else if (r_r.busy && !r_r.hold)
		begin
			r_nxt.cnt = r_r.cnt + 8'h01;
			if (r_r.cnt == hp - 8'h01)
			begin
				r_nxt.cnt = 8'h00;
				r_nxt.sclk = ~r_r.sclk;
				if (!r_r.sclk && r_r.rd) // RQ3 RQ4
				begin
					case (r_r.lanes)
						qnfe_pkg::LN_4: r_nxt.rx = {r_r.rx[3:0], link.io};
						qnfe_pkg::LN_2: r_nxt.rx = {r_r.rx[5:0], link.io[1:0]};
						default: r_nxt.rx = {r_r.rx[6:0], link.io[1]};
					endcase
				end
				if (r_r.sclk)
				begin
					r_nxt.bits = r_r.bits - wv;
					if (r_r.bits == wv)
						r_nxt.busy = 1'b0;
					else
						shift_now = 1'b1;
				end
			end
		end

		// Data moves onto the lanes only while the clock is low.
		if (shift_now) // RQ3 RQ4
		begin
			case (r_r.lanes)
				qnfe_pkg::LN_4: r_nxt.io_o = src[7:4];
				qnfe_pkg::LN_2: r_nxt.io_o[1:0] = src[7:6];
				default: r_nxt.io_o[0] = src[7];
			endcase
			r_nxt.sr = src << wv;
		end

		if (r_nxt.lanes == qnfe_pkg::LN_4) // RQ5 RQ11
			r_nxt.oe_n = r_nxt.rd ? 4'hf : 4'h0;
		else
		begin
			r_nxt.io_o[2] = r_nxt.wp;
			r_nxt.io_o[3] = ~r_nxt.hold; // RQ12
			r_nxt.oe_n = 4'h2;
			if (r_nxt.lanes == qnfe_pkg::LN_2)
				r_nxt.oe_n = r_nxt.rd ? 4'h3 : 4'h0;
		end

		if (rd_in)
		begin
			case (addr_in)
				qnfe_pkg::H_CTRL: r_nxt.rdata = ctrlv;
				qnfe_pkg::H_DATA: r_nxt.rdata = r_r.rx;
				qnfe_pkg::H_STAT: r_nxt.rdata = {7'h00, r_r.busy};
				qnfe_pkg::H_DIV: r_nxt.rdata = r_r.div;
				default: r_nxt.rdata = 8'h00;
			endcase
		end

		if (reset_in)
		begin
			r_nxt = '0;
			r_nxt.cs_n = 1'b1;
			r_nxt.wp = 1'b1;
			r_nxt.io_o = 4'hc;
			r_nxt.oe_n = 4'h2;
			r_nxt.div = qnfe_pkg::DIV_RST;
		end
	end

	always_ff @(posedge clk_in)
	begin
		r_r <= r_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	assign link.cs_n = r_r.cs_n;
	assign link.sclk = r_r.sclk;
	assign link.h_io_o = r_r.io_o;
	assign link.h_io_oe_n = r_r.oe_n;
	assign rdata_out = r_r.rdata;
endmodule

// >>> hdl/qnfe_link_if.sv
`timescale 1ns/1ps
interface qnfe_link_if;
	logic cs_n;
	logic sclk;
	logic [3:0] h_io_o;
	logic [3:0] h_io_oe_n;
	logic [3:0] d_io_o;
	logic [3:0] d_io_oe_n;
	logic [3:0] io;

	// Wire level: a driving end sets it, an undriven lane floats high.
	assign io = (~h_io_oe_n & h_io_o) | (~d_io_oe_n & d_io_o) | (h_io_oe_n & d_io_oe_n);

	modport host_mp (output cs_n, output sclk, output h_io_o, output h_io_oe_n, input io);
	modport dev_mp (input cs_n, input sclk, input io, output d_io_o, output d_io_oe_n);
endinterface

// >>> hdl/qnfe_pkg.sv
package qnfe_pkg;
	// Array organisation.
	localparam int PAGE_BYTES = 2048;
	localparam int COL_W = 11;
	localparam int PAGE_W = 16;
	localparam int BLOCK_LSB = 6;
	localparam int UNIT_LSB = 7;
	localparam logic [15:0] OTP_PAGES = 16'h000a;
	localparam logic [9:0] PROT_UNITS = 10'h200;
	localparam logic [3:0] BPF_ALL = 4'ha;
	// Instruction codes.
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_GETR = 8'h0f;
	localparam logic [7:0] OP_SETR = 8'h1f;
	localparam logic [7:0] OP_LOADS = 8'h02;
	localparam logic [7:0] OP_LOADQ = 8'h32;
	localparam logic [7:0] OP_PROG = 8'h10;
	localparam logic [7:0] OP_ERASE = 8'hd8;
	localparam logic [7:0] OP_PREAD = 8'h13;
	localparam logic [7:0] OP_READ1 = 8'h03;
	localparam logic [7:0] OP_READ2 = 8'h3b;
	localparam logic [7:0] OP_READ4 = 8'h6b;
	// Device register selectors, fields and reset values.
	localparam logic [7:0] RA_PROT = 8'ha0;
	localparam logic [7:0] RA_CONF = 8'hb0;
	localparam logic [7:0] RA_STAT = 8'hc0;
	localparam int PROT_RP1 = 0;
	localparam int PROT_WPE = 1;
	localparam int PROT_BPF_LO = 3;
	localparam int PROT_RP0 = 7;
	localparam logic [7:0] PROT_RST = 8'h00;
	localparam logic [7:0] CONF_RST = 8'h00;
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_REF = 2;
	localparam int ST_ECC_LO = 4;
	localparam logic [1:0] AREA_MAIN = 2'h0;
	localparam logic [1:0] AREA_OTP = 2'h1;
	localparam logic [1:0] AREA_UNIQ = 2'h2;
	localparam logic [1:0] AREA_PARAM = 2'h3;
	// Lane codes and array operation kinds.
	localparam logic [1:0] LN_1 = 2'h0;
	localparam logic [1:0] LN_2 = 2'h1;
	localparam logic [1:0] LN_4 = 2'h2;
	localparam logic [1:0] OPK_READ = 2'h0;
	localparam logic [1:0] OPK_PROG = 2'h1;
	localparam logic [1:0] OPK_ERASE = 2'h2;
	// Host registers and fields.
	localparam logic [7:0] H_CTRL = 8'h00;
	localparam logic [7:0] H_DATA = 8'h04;
	localparam logic [7:0] H_STAT = 8'h08;
	localparam logic [7:0] H_DIV = 8'h0c;
	localparam int CTRL_SEL = 0;
	localparam int CTRL_HOLD = 1;
	localparam int CTRL_WP = 2;
	localparam int CTRL_LN_LO = 4;
	localparam int CTRL_RD = 6;
	// Link clock timing.
	localparam int CLK_PERIOD_NS = 5;
	localparam int LINK_PERIOD_NS = 160;
	localparam logic [7:0] DIV_RST = 8'(LINK_PERIOD_NS / (2 * CLK_PERIOD_NS));
	localparam logic [7:0] DIV_MIN = 8'h08;
endpackage
